// ---- rtl/lnmc_mode_ctrl.sv ----
// mode state machine, transmit supervision, wake flags, watchdog and reset delay
`timescale 1ns/1ns
module lnmc_mode_ctrl import lnmc_pkg::*; #(
	parameter int RESET_DELAY = RESET_DELAY_CYC,
	parameter int STANDBY_TIMEOUT = STANDBY_TIMEOUT_CYC,
	parameter int TX_DOM_TIMEOUT = TX_DOM_TIMEOUT_CYC,
	parameter int WD_CLOSED = WD_CLOSED_CYC,
	parameter int WD_OPEN = WD_OPEN_CYC
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire lnmc_pins_type pins,
	output lnmc_outs_type outs,
	output lnmc_mode_type mode,
	output logic txPathEnabled,
	output logic lowSlew
);
	// nrst is the battery power-on / undervoltage reset: below 4 V the whole block is held
	localparam logic [FILT_W-1:0] EN_DEB_LEN = FILT_W'(EN_DEBOUNCE_CYC);
	localparam logic [FILT_W-1:0] IGN_LEN = FILT_W'(IGN_FILTER_CYC);
	localparam logic [FILT_W-1:0] ONE_LEN = 16'h0001;

	logic enSync, enDeb, txSync, lwSync, ignSync, ignDeb, kickSync, wdmSync, vccSync;
	logic [SYNC_N-1:0] rawVec, syncVec, filtVec;
	assign rawVec = {pins.enable, pins.txData, pins.localWake, pins.ignitionWake,
		pins.watchdogKick, pins.watchdogMode, pins.vccUnder};

	genvar gi;
	generate
		for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
			lnmc_filter #(
				.LEN(gi == 6 ? EN_DEB_LEN : (gi == 3 ? IGN_LEN : ONE_LEN))
			) u_filt (
				.clk_sys(clk_sys),
				.nrst(nrst),
				.rawIn(rawVec[gi]),
				.resetVal(1'b0),
				.syncOut(syncVec[gi]),
				.filtOut(filtVec[gi])
			);
		end
	endgenerate

	assign enSync = syncVec[6];
	assign enDeb = filtVec[6];
	assign txSync = syncVec[5];
	assign lwSync = syncVec[4];
	assign ignSync = syncVec[3];
	assign ignDeb = filtVec[3];
	assign kickSync = syncVec[2];
	assign wdmSync = syncVec[1];
	assign vccSync = syncVec[0];

	function automatic logic isLowPower(input lnmc_mode_type m);
		isLowPower = (m == MODE_SILENT) || (m == MODE_SLEEP);
	endfunction : isLowPower

	// edge history
	logic enPrev, txPrev, lwPrev, ignPrev, kickPrev, started;
	logic enRise, enFall, txFall, lwFall, ignRise, kickFall;
	assign enRise = started && enDeb && !enPrev;
	assign enFall = started && !enDeb && enPrev;
	assign txFall = started && !txSync && txPrev;
	assign lwFall = started && !lwSync && lwPrev;
	assign ignRise = started && ignDeb && !ignPrev;
	assign kickFall = started && !kickSync && kickPrev;

	// mode and timers
	lnmc_mode_type next_mode;
	logic [CNT_W-1:0] modeCnt, next_modeCnt;
	logic pendNormal, next_pendNormal;
	logic wakeIrq, next_wakeIrq, localFlag, next_localFlag;
	logic slewSet, next_slewSet, next_lowSlew;
	logic [CNT_W-1:0] domCnt, next_domCnt;
	logic domRun, next_domRun, next_txPath;
	logic [CNT_W-1:0] wdCnt, next_wdCnt;
	logic wdFault, next_wdFault;
	logic [CNT_W-1:0] porCnt, next_porCnt;
	logic porDone, next_porDone;
	logic wake, localEvt;

	assign localEvt = isLowPower(mode) && lwFall;
	assign wake = localEvt || (isLowPower(mode) && ignRise);

	always_comb begin
		next_mode = mode;
		next_modeCnt = modeCnt;
		next_pendNormal = pendNormal;
		next_wakeIrq = wakeIrq;
		next_localFlag = localFlag;
		next_slewSet = slewSet;
		next_lowSlew = lowSlew;
		if (enRise) begin
			next_wakeIrq = 1'b0;
			next_localFlag = 1'b0;
			if (!slewSet) begin
				next_slewSet = 1'b1;
				next_lowSlew = !txSync;
			end
		end
		if (wake) begin
			next_wakeIrq = 1'b1;
		end
		if (localEvt || (isLowPower(mode) && ignRise)) begin
			next_localFlag = 1'b1;
		end
		if (!started) begin
			next_mode = MODE_STANDBY;
			next_modeCnt = '0;
		end else begin
			case (mode)
				MODE_STANDBY: begin
					if (enRise && !pendNormal) begin
						next_pendNormal = 1'b1;
						next_modeCnt = '0;
					end else if (pendNormal) begin
						if (!enDeb) begin
							next_pendNormal = 1'b0;
						end else if (modeCnt >= CNT_W'(EN_TO_NORMAL_CYC - 1)) begin
							next_mode = MODE_NORMAL;
							next_pendNormal = 1'b0;
							next_modeCnt = '0;
						end else begin
							next_modeCnt = modeCnt + 1'b1;
						end
					end else if (modeCnt >= CNT_W'(STANDBY_TIMEOUT - 1)) begin
						next_mode = MODE_SLEEP;
						next_modeCnt = '0;
					end else begin
						next_modeCnt = modeCnt + 1'b1;
					end
				end
				MODE_NORMAL: begin
					if (vccSync) begin
						next_mode = MODE_STANDBY;
						next_modeCnt = '0;
					end else if (enFall) begin
						next_mode = txSync ? MODE_SILENT : MODE_SLEEP;
					end
				end
				MODE_SILENT: begin
					if (vccSync || wake) begin
						next_mode = MODE_STANDBY;
						next_modeCnt = '0;
					end else if (enRise) begin
						next_mode = MODE_NORMAL;
					end
				end
				MODE_SLEEP: begin
					if (wake) begin
						next_mode = MODE_STANDBY;
						next_modeCnt = '0;
					end else if (enDeb) begin
						next_mode = MODE_NORMAL;
					end
				end
				default: next_mode = MODE_STANDBY;
			endcase
		end
	end

	// transmit supervision
	always_comb begin
		next_txPath = txPathEnabled;
		next_domCnt = domCnt;
		next_domRun = domRun;
		if (mode != MODE_NORMAL) begin
			next_txPath = 1'b0;
			next_domRun = 1'b0;
			next_domCnt = '0;
		end else if (!txPathEnabled) begin
			if (txSync) begin
				next_txPath = 1'b1;
			end
		end else begin
			if (txFall) begin
				next_domRun = 1'b1;
				next_domCnt = '0;
			end else if (domRun && !txSync) begin
				if (domCnt >= CNT_W'(TX_DOM_TIMEOUT - 1)) begin
					next_txPath = 1'b0;
					next_domRun = 1'b0;
					next_domCnt = '0;
				end else begin
					next_domCnt = domCnt + 1'b1;
				end
			end else if (txSync) begin
				next_domRun = 1'b0;
				next_domCnt = '0;
			end
		end
	end

	// window watchdog: closed window then open window; kick in closed or none in time is a fault
	always_comb begin
		next_wdCnt = wdCnt;
		next_wdFault = 1'b0;
		if (wdmSync || isLowPower(mode) || !porDone) begin
			next_wdCnt = '0;
		end else if (kickFall) begin
			next_wdCnt = '0;
			next_wdFault = (wdCnt < CNT_W'(WD_CLOSED));
		end else if (wdCnt >= CNT_W'(WD_CLOSED + WD_OPEN - 1)) begin
			next_wdCnt = '0;
			next_wdFault = 1'b1;
		end else begin
			next_wdCnt = wdCnt + 1'b1;
		end
	end

	// power-on delay, restarted by a watchdog fault so the reset pulse has length
	always_comb begin
		next_porCnt = porCnt;
		next_porDone = porDone;
		if (wdFault) begin
			next_porCnt = '0;
			next_porDone = 1'b0;
		end else if (!porDone) begin
			if (porCnt >= CNT_W'(RESET_DELAY - 1)) begin
				next_porDone = 1'b1;
			end else begin
				next_porCnt = porCnt + 1'b1;
			end
		end
	end

	lnmc_outs_type next_outs;
	always_comb begin
		next_outs.linDrive = (next_mode == MODE_NORMAL) && next_txPath && !txSync;
		next_outs.rxdLow = (next_mode == MODE_STANDBY) && next_wakeIrq;
		next_outs.txdLow = (next_mode == MODE_STANDBY) && next_localFlag;
		next_outs.supplySwitch = !isLowPower(next_mode);
		next_outs.resetOutN = next_porDone && !vccSync;
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			mode <= MODE_STANDBY;
			modeCnt <= '0;
			pendNormal <= 1'b0;
			wakeIrq <= 1'b0;
			localFlag <= 1'b0;
			slewSet <= 1'b0;
			lowSlew <= 1'b0;
			txPathEnabled <= 1'b0;
			domCnt <= '0;
			domRun <= 1'b0;
			wdCnt <= '0;
			wdFault <= 1'b0;
			porCnt <= '0;
			porDone <= 1'b0;
			outs <= '{linDrive: 1'b0, rxdLow: 1'b0, txdLow: 1'b0, supplySwitch: 1'b1, resetOutN: 1'b0};
			started <= 1'b0;
			enPrev <= 1'b0;
			txPrev <= 1'b1;
			lwPrev <= 1'b1;
			ignPrev <= 1'b0;
			kickPrev <= 1'b1;
		end else begin
			mode <= next_mode;
			modeCnt <= next_modeCnt;
			pendNormal <= next_pendNormal;
			wakeIrq <= next_wakeIrq;
			localFlag <= next_localFlag;
			slewSet <= next_slewSet;
			lowSlew <= next_lowSlew;
			txPathEnabled <= next_txPath;
			domCnt <= next_domCnt;
			domRun <= next_domRun;
			wdCnt <= next_wdCnt;
			wdFault <= next_wdFault;
			porCnt <= next_porCnt;
			porDone <= next_porDone;
			outs <= next_outs;
			// edge history is primed one cycle late so reset levels never look like edges
			started <= 1'b1;
			enPrev <= enDeb;
			txPrev <= txSync;
			lwPrev <= lwSync;
			ignPrev <= ignDeb;
			kickPrev <= kickSync;
		end
	end
endmodule : lnmc_mode_ctrl

// ---- rtl/lnmc_pkg.sv ----
// constants, mode enum and pin bundles of the lin node mode controller
package lnmc_pkg;
	localparam int CLK_MHZ = 100;
	localparam int CLK_PERIOD_NS = 10;
	// figures in their own units
	localparam int RESET_DELAY_MS = 4;
	localparam int STANDBY_TIMEOUT_MS = 350;
	localparam int IGN_FILTER_US = 250;
	localparam int EN_DEBOUNCE_US = 10;
	localparam int EN_TO_NORMAL_US = 10;
	localparam int TX_DOM_TIMEOUT_MS = 10;
	localparam int WD_CLOSED_MS = 20;
	localparam int WD_OPEN_MS = 20;
	// derived counts
	localparam int RESET_DELAY_CYC = RESET_DELAY_MS * 1000 * CLK_MHZ;
	localparam int STANDBY_TIMEOUT_CYC = STANDBY_TIMEOUT_MS * 1000 * CLK_MHZ;
	localparam int IGN_FILTER_CYC = IGN_FILTER_US * CLK_MHZ + 1;
	localparam int EN_DEBOUNCE_CYC = EN_DEBOUNCE_US * CLK_MHZ;
	localparam int EN_TO_NORMAL_CYC = EN_TO_NORMAL_US * CLK_MHZ;
	localparam int TX_DOM_TIMEOUT_CYC = TX_DOM_TIMEOUT_MS * 1000 * CLK_MHZ;
	localparam int WD_CLOSED_CYC = WD_CLOSED_MS * 1000 * CLK_MHZ;
	localparam int WD_OPEN_CYC = WD_OPEN_MS * 1000 * CLK_MHZ;
	localparam int CNT_W = 28;
	localparam int FILT_W = 16;
	localparam int SYNC_N = 7;

	// gray along standby -> normal -> silent -> sleep
	typedef enum logic [1:0] {
		MODE_STANDBY = 2'b00,
		MODE_NORMAL = 2'b01,
		MODE_SILENT = 2'b11,
		MODE_SLEEP = 2'b10
	} lnmc_mode_type;

	typedef struct packed {
		logic enable;
		logic txData;
		logic localWake;
		logic ignitionWake;
		logic watchdogKick;
		logic watchdogMode;
		logic vccUnder;
	} lnmc_pins_type;

	typedef struct packed {
		logic linDrive;
		logic rxdLow;
		logic txdLow;
		logic supplySwitch;
		logic resetOutN;
	} lnmc_outs_type;
endpackage : lnmc_pkg

// ---- rtl/lnmc_filter.sv ----
// two-flop synchroniser with a stability filter of settable length
`timescale 1ns/1ns
module lnmc_filter import lnmc_pkg::*; #(
	parameter logic [FILT_W-1:0] LEN = 16'h0001
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic rawIn,
	input wire logic resetVal,
	output logic syncOut,
	output logic filtOut
);
	logic meta;
	logic [FILT_W-1:0] count;
	logic [FILT_W-1:0] next_count;
	logic next_filt;
	logic loadVal;

	always_comb begin
		next_count = count;
		next_filt = filtOut;
		if (syncOut == filtOut) begin
			next_count = '0;
		end else if (count >= LEN - 16'h0001) begin
			next_count = '0;
			next_filt = syncOut;
		end else begin
			next_count = count + 16'h0001;
		end
	end

	assign loadVal = resetVal;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			meta <= 1'b0;
			syncOut <= 1'b0;
			count <= '0;
			filtOut <= 1'b0;
		end else begin
			meta <= rawIn;
			syncOut <= meta;
			count <= next_count;
			filtOut <= next_filt;
		end
	end
endmodule : lnmc_filter

// ---- sim/lnmc_monitor.sv ----
// port assertions for the lin node mode controller
`timescale 1ns/1ns
module lnmc_monitor import lnmc_pkg::*; #(
	parameter int RESET_DELAY = RESET_DELAY_CYC,
	parameter int TX_DOM_TIMEOUT = TX_DOM_TIMEOUT_CYC
) (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire lnmc_pins_type pins,
	input wire lnmc_outs_type outs,
	input wire lnmc_mode_type mode,
	input wire logic txPathEnabled,
	input wire logic lowSlew
);
	// saturating: cycles since release, cycles of dominant data in normal
	// counter width follows the design so the full-length delays are reachable
	logic [CNT_W-1:0] relCnt;
	logic [CNT_W-1:0] domCnt;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			relCnt <= '0;
			domCnt <= '0;
		end else begin
			relCnt <= relCnt + CNT_W'(relCnt != '1);
			domCnt <= (pins.txData || mode != MODE_NORMAL) ? '0 : domCnt + CNT_W'(domCnt != '1);
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	a_supply_by_mode: assert property (mode == $past(mode) |-> outs.supplySwitch == (mode inside {MODE_STANDBY, MODE_NORMAL}))
		else $error("supply switch disagrees with mode");
	a_bus_idle_off: assert property (mode != MODE_NORMAL && $past(mode) != MODE_NORMAL |-> !outs.linDrive)
		else $error("bus driven outside normal");
	a_path_gates_bus: assert property (!txPathEnabled && !$past(txPathEnabled) |-> !outs.linDrive)
		else $error("bus driven with path off");
	a_reset_hold: assert property (relCnt < RESET_DELAY - 2 |-> !outs.resetOutN)
		else $error("reset released early");
	a_under_reset: assert property (pins.vccUnder [*5] |-> !outs.resetOutN)
		else $error("reset out high in undervoltage");
	a_dom_timeout: assert property (domCnt == TX_DOM_TIMEOUT + 8 |-> !txPathEnabled)
		else $error("dominant timeout missed");
	a_flags_standby: assert property (mode != MODE_STANDBY && $past(mode) != MODE_STANDBY |-> !outs.rxdLow && !outs.txdLow)
		else $error("wake flags shown outside standby");
	a_wake_standby: assert property ($fell(pins.localWake) && mode inside {MODE_SLEEP, MODE_SILENT} |-> ##[1:8] mode == MODE_STANDBY)
		else $error("local wake ignored");
endmodule : lnmc_monitor

bind lnmc_mode_ctrl lnmc_monitor #(.RESET_DELAY(RESET_DELAY), .TX_DOM_TIMEOUT(TX_DOM_TIMEOUT)) lnmc_monitor_inst (
	.clk_sys(clk_sys), .nrst(nrst), .pins(pins), .outs(outs), .mode(mode),
	.txPathEnabled(txPathEnabled), .lowSlew(lowSlew));

// ---- sim/lnmc_mcu_model.sv ----
// controller-side model: watchdog kicks placed in the open window
`timescale 1ns/1ns
module lnmc_mcu_model (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic kickOn,
	input wire logic resetOutN,
	output logic watchdogKick
);
	logic [5:0] phase;
	logic [5:0] next_phase;
	// phase restarts while reset is held, so kicks follow the device watchdog start
	always_comb begin
		next_phase = (kickOn && resetOutN) ? phase + 6'h1 : 6'h0;
	end
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) phase <= 6'h0;
		else phase <= next_phase;
	end
	// low four cycles from phase 60: falls mid open window, long enough for the synchroniser
	assign watchdogKick = !(phase >= 6'h3c);
endmodule : lnmc_mcu_model

// ---- sim/test_lnmc_mode_ctrl.sv ----
// self-checking bench for the mode controller
`timescale 1ns/1ns
module test_lnmc_mode_ctrl import lnmc_pkg::*;;
	logic clk_sys = 0, nrst = 0, enable = 0, txData = 1, localWake = 1, ignitionWake = 0;
	logic wdMode = 1, vccUnder = 0, kickOn = 0, kick, txPathEnabled, lowSlew;
	lnmc_pins_type pins;
	lnmc_outs_type outs;
	lnmc_mode_type mode;
	int fail_count = 0, total_checks = 0, i;
	always #5 clk_sys = ~clk_sys;
	assign pins = {enable, txData, localWake, ignitionWake, kick, wdMode, vccUnder};
	lnmc_mode_ctrl #(.RESET_DELAY(50), .STANDBY_TIMEOUT(3000), .TX_DOM_TIMEOUT(100), .WD_CLOSED(40),
		.WD_OPEN(40)) lnmc_mode_ctrl_inst (.clk_sys(clk_sys), .nrst(nrst), .pins(pins), .outs(outs),
		.mode(mode), .txPathEnabled(txPathEnabled), .lowSlew(lowSlew));
	lnmc_mcu_model lnmc_mcu_model_inst (.clk_sys(clk_sys), .nrst(nrst), .kickOn(kickOn),
		.resetOutN(outs.resetOutN), .watchdogKick(kick));
	task results;
		if (fail_count == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : results
	task check(input logic [1:0] seen, input logic [1:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	// inputs always move 1 ns after the rising edge
	task cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : cyc
	task waitMode(input lnmc_mode_type m, input int lim);
		for (int k = 0; k < lim && mode !== m; k++) cyc(1);
		check(mode, m);
		if (mode !== m) results();
	endtask : waitMode
	initial begin
		cyc(5);
		nrst = 1;
		check(outs.supplySwitch, 1'h1);
		check(outs.resetOutN, 1'h0);
		cyc(60);
		check(outs.resetOutN, 1'h1);
		check(mode, MODE_STANDBY);
		waitMode(MODE_SLEEP, 3100);
		check(outs.supplySwitch, 1'h0);
		localWake = 0;
		waitMode(MODE_STANDBY, 10);
		cyc(2);
		check(outs.rxdLow, 1'h1);
		check(outs.txdLow, 1'h1);
		localWake = 1;
		enable = 1;
		cyc(1500);
		check(mode, MODE_STANDBY);
		check(outs.rxdLow, 1'h0);
		check(outs.txdLow, 1'h0);
		waitMode(MODE_NORMAL, 700);
		check(outs.rxdLow, 1'h0);
		check(outs.txdLow, 1'h0);
		check(lowSlew, 1'h0);
		cyc(4);
		check(txPathEnabled, 1'h1);
		txData = 0;
		cyc(5);
		check(outs.linDrive, 1'h1);
		txData = 1;
		cyc(5);
		check(outs.linDrive, 1'h0);
		txData = 0;
		cyc(80);
		txData = 1;
		cyc(2);
		txData = 0;
		cyc(80);
		check(txPathEnabled, 1'h1);
		cyc(40);
		check(txPathEnabled, 1'h0);
		check(outs.linDrive, 1'h0);
		txData = 1;
		cyc(5);
		check(txPathEnabled, 1'h1);
		enable = 0;
		cyc(500);
		enable = 1;
		cyc(1200);
		check(mode, MODE_NORMAL);
		// phase may start misaligned, so one fault is allowed to settle it
		wdMode = 0;
		kickOn = 1;
		cyc(300);
		for (i = 0; i < 300; i++) begin
			cyc(1);
			check(outs.resetOutN, 1'h1);
		end
		kickOn = 0;
		for (i = 0; i < 120 && outs.resetOutN !== 0; i++) cyc(1);
		check(outs.resetOutN, 1'h0);
		wdMode = 1;
		// watch well past one full window: a running watchdog would fault in this span
		for (i = 0; i < 200; i++) begin
			cyc(1);
			if (i >= 59) check(outs.resetOutN, 1'h1);
		end
		vccUnder = 1;
		waitMode(MODE_STANDBY, 8);
		cyc(4);
		check(outs.resetOutN, 1'h0);
		vccUnder = 0;
		waitMode(MODE_NORMAL, 3200);
		enable = 0;
		waitMode(MODE_SILENT, 1100);
		check(outs.supplySwitch, 1'h0);
		ignitionWake = 1;
		cyc(24000);
		check(mode, MODE_SILENT);
		waitMode(MODE_STANDBY, 1100);
		check(outs.rxdLow, 1'h1);
		ignitionWake = 0;
		enable = 1;
		waitMode(MODE_NORMAL, 2200);
		txData = 0;
		enable = 0;
		waitMode(MODE_SLEEP, 1100);
		results();
	end
endmodule : test_lnmc_mode_ctrl
